/* File: rtl/mic_pkg.sv */
`default_nettype none
package mic_pkg;
  // Avalon byte address width; register byte address is index times four
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int PC_W = 13;
  localparam int PORT_W = 8;
  localparam int SYNC_STAGES = 2;
  // Register indices
  localparam logic [7:0] IDX_CORE_CTRL = 8'h0b;
  localparam logic [7:0] IDX_PFLAG_A = 8'h0c;
  localparam logic [7:0] IDX_PFLAG_B = 8'h0d;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PEN_A = 8'h8c;
  localparam logic [7:0] IDX_PEN_B = 8'h8d;
  localparam logic [7:0] IDX_ANALOG_SEL = 8'h91;
  localparam logic [7:0] IDX_PIN_CHG_EN = 8'h96;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h97;
  // Core interrupt control fields
  localparam int BIT_GLB_EN = 7;
  localparam int BIT_GRP_EN = 6;
  localparam int BIT_TMR_EN = 5;
  localparam int BIT_EDGE_EN = 4;
  localparam int BIT_CHG_EN = 3;
  localparam int BIT_TMR_FLAG = 2;
  localparam int BIT_EDGE_FLAG = 1;
  localparam int BIT_CHG_FLAG = 0;
  // Option register: edge polarity
  localparam int BIT_EDGE_POL = 6;
  // Port pin carrying the external edge interrupt
  localparam int EXT_PIN_BIT = 0;
  // Reset values
  localparam logic [7:0] CORE_CTRL_RST = 8'h00;
  localparam logic [7:0] PFLAG_RST = 8'h00;
  localparam logic [7:0] PEN_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'h00;
  localparam logic [7:0] ANALOG_SEL_RST = 8'h00;
  localparam logic [7:0] PIN_CHG_EN_RST = 8'h00;
  // Implemented bits of the second peripheral flag and enable registers
  localparam logic [7:0] PFLAG_B_MASK = 8'hf5;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  // Instruction cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCY_NS = 40;
  localparam int PHASES_PER_TCY = TCY_NS / CLK_PERIOD_NS;
  localparam int LAT_MIN_TCY = 3;
  localparam int LAT_MAX_TCY = 4;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mic_phase_t;
  typedef enum logic [1:0] {ST_RUN, ST_FINISH, ST_DUMMY1, ST_DUMMY2} mic_state_t;
endpackage : mic_pkg
`default_nettype wire

/* File: rtl/mic_sync.sv */
`default_nettype none
module mic_sync
  import mic_pkg::*;
#(
  parameter int W = 8
)(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] meta;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      meta <= '0;
      Q <= '0;
    end
    else
    begin
      meta <= D;
      Q <= meta;
    end
  end
endmodule : mic_sync
`default_nettype wire

/* File: rtl/mic_irq_ctrl.sv */
// Function
// R1 - Interrupts reach the core only while global enable is one.
// R2 - Global enable clears on every reset.
// R3 - Return-from-interrupt instruction sets global enable.
// R4 - Service clears global enable, pushes return address, vectors to 0004h.
// R5 - External events vector within three to four instruction cycles.
// R6 - Latency does not depend on one- or two-cycle instructions.
// R7 - Flags set on events whatever the enable bits are.
// R8 - Clearing global enable suppresses the next-cycle request; it stays pending.
// R9 - Software clears handled flags before re-enabling interrupts.
// R10 - Edge pin flag set on rising or falling edge by polarity bit.
// R11 - Edge pin wakes from sleep only when its enable is set.
// R12 - Edge flag sets only from phase four through phase one.
// R13 - Timer-zero wrap sets its flag, gated by its enable.
// R14 - Port change sets its flag, gated by enable and per-pin enables.
// R15 - A change during a port read may fail to set the flag.
// R16 - Active display segment function disables the edge pin interrupt.
// R17 - Analogue pins read zero and trigger no digital interrupts.
// R18 - Only the return address is saved on interrupt entry.
// R19 - Enabled flagged interrupt wakes from sleep regardless of global enable.
// R20 - Peripheral flags also need the peripheral group enable.
// R21 - One vector request from the OR of all qualified pairs.
`default_nettype none
module mic_irq_ctrl
  import mic_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [ADDR_W-1:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [DATA_W-1:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [DATA_W-1:0] READDATA,
  output logic WAITREQUEST,
  input wire logic [PORT_W-1:0] PORT_B_PINS,
  input wire logic SEG_ACTIVE,
  input wire logic TIMER_ZERO_WRAP,
  input wire logic [REG_W-1:0] PERIPH_EVENT_A,
  input wire logic [REG_W-1:0] PERIPH_EVENT_B,
  input wire logic PORT_READ,
  input wire logic INSTR_IRQ_RETURN,
  input wire logic SLEEPING,
  output logic VECTOR_REQ,
  output logic STACK_PUSH,
  output logic [PC_W-1:0] VECTOR_ADDR,
  output logic WAKE
);
  ////////////////////////////////////////////////////////////////////////////
  // Phase generator
  mic_phase_t phase;
  logic q1;
  logic flag_window;
  assign q1 = (phase == PH_Q1);
  assign flag_window = (phase == PH_Q4) || (phase == PH_Q1);

  always_ff @(posedge CLK)
  begin
    if (RESET)
      phase <= PH_Q1;
    else
      phase <= mic_phase_t'(phase + 2'h1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic glb_en;
  logic grp_en;
  logic tmr_en;
  logic edge_en;
  logic chg_en;
  logic tmr_flag;
  logic edge_flag;
  logic chg_flag;
  logic irq_line;
  logic [REG_W-1:0] pflag_a;
  logic [REG_W-1:0] pflag_b;
  logic [REG_W-1:0] pen_a;
  logic [REG_W-1:0] pen_b;
  logic [REG_W-1:0] option_reg;
  logic [REG_W-1:0] analog_sel;
  logic [REG_W-1:0] pin_chg_en;
  mic_state_t state;
  mic_state_t next_state;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave decode
  logic [7:0] idx;
  logic aligned;
  logic bus_wr;
  logic wr_core;
  logic wr_pfa;
  logic wr_pfb;
  logic wr_pea;
  logic wr_peb;
  logic wr_opt;
  logic wr_ans;
  logic wr_pce;
  logic [REG_W-1:0] wd;
  logic [REG_W-1:0] core_ctrl;
  logic [REG_W-1:0] irq_status;
  logic [REG_W-1:0] rd_mux;
  assign idx = ADDRESS[ADDR_W-1:2];
  assign aligned = (ADDRESS[1:0] == 2'h0);
  assign bus_wr = WRITE && !WAITREQUEST && BYTEENABLE[0] && aligned;
  assign wd = WRITEDATA[REG_W-1:0];
  assign wr_core = bus_wr && (idx == IDX_CORE_CTRL);
  assign wr_pfa = bus_wr && (idx == IDX_PFLAG_A);
  assign wr_pfb = bus_wr && (idx == IDX_PFLAG_B);
  assign wr_pea = bus_wr && (idx == IDX_PEN_A);
  assign wr_peb = bus_wr && (idx == IDX_PEN_B);
  assign wr_opt = bus_wr && (idx == IDX_OPTION);
  assign wr_ans = bus_wr && (idx == IDX_ANALOG_SEL);
  assign wr_pce = bus_wr && (idx == IDX_PIN_CHG_EN);
  assign core_ctrl = {glb_en, grp_en, tmr_en, edge_en, chg_en, tmr_flag, edge_flag, chg_flag};
  assign irq_status = {5'h00, (state != ST_RUN), WAKE, irq_line};
  assign rd_mux = !aligned ? 8'h00 :
                  (idx == IDX_CORE_CTRL) ? core_ctrl :
                  (idx == IDX_PFLAG_A) ? pflag_a :
                  (idx == IDX_PFLAG_B) ? pflag_b :
                  (idx == IDX_PEN_A) ? pen_a :
                  (idx == IDX_PEN_B) ? pen_b :
                  (idx == IDX_OPTION) ? option_reg :
                  (idx == IDX_ANALOG_SEL) ? analog_sel :
                  (idx == IDX_PIN_CHG_EN) ? pin_chg_en :
                  (idx == IDX_IRQ_STATUS) ? irq_status : 8'h00;

  // One wait cycle, then a single low cycle carrying the answer
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      WAITREQUEST <= 1'b1;
      READDATA <= '0;
    end
    else
    begin
      WAITREQUEST <= !((READ || WRITE) && WAITREQUEST);
      if (READ && WAITREQUEST)
        READDATA <= {{(DATA_W-REG_W){1'b0}}, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin conditioning
  logic [PORT_W-1:0] pins_sync;
  logic [PORT_W-1:0] port_view;
  logic [PORT_W-1:0] port_snap;
  logic ext_prev;
  logic ext_edge;
  logic edge_pend;
  logic port_change;

  mic_sync #(.W(PORT_W)) u_pin_sync (
    .CLK(CLK),
    .RESET(RESET),
    .D(PORT_B_PINS),
    .Q(pins_sync)
  );

  assign port_view = pins_sync & ~analog_sel; // R17
  assign ext_edge = !SEG_ACTIVE && // R16
                    (option_reg[BIT_EDGE_POL] ? (port_view[EXT_PIN_BIT] && !ext_prev)
                                              : (!port_view[EXT_PIN_BIT] && ext_prev)); // R10
  // Mismatch against the value latched by the last port read
  assign port_change = |((port_view ^ port_snap) & pin_chg_en); // R14

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      ext_prev <= 1'b0;
      edge_pend <= 1'b0;
      port_snap <= '0;
    end
    else
    begin
      ext_prev <= port_view[EXT_PIN_BIT];
      edge_pend <= (ext_edge || edge_pend) && !flag_window; // R12
      // A change landing with the read is absorbed into the snapshot
      if (PORT_READ && (phase == PH_Q2))
        port_snap <= port_view; // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over software clear
  logic edge_flag_set;
  assign edge_flag_set = (ext_edge || edge_pend) && flag_window; // R12

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      {grp_en, tmr_en, edge_en, chg_en} <= CORE_CTRL_RST[BIT_GRP_EN:BIT_CHG_EN];
      {tmr_flag, edge_flag, chg_flag} <= CORE_CTRL_RST[BIT_TMR_FLAG:BIT_CHG_FLAG];
      pflag_a <= PFLAG_RST;
      pflag_b <= PFLAG_RST;
      pen_a <= PEN_RST;
      pen_b <= PEN_RST;
      option_reg <= OPTION_RST;
      analog_sel <= ANALOG_SEL_RST;
      pin_chg_en <= PIN_CHG_EN_RST;
    end
    else
    begin
      if (wr_core)
        {grp_en, tmr_en, edge_en, chg_en} <= wd[BIT_GRP_EN:BIT_CHG_EN];
      tmr_flag <= TIMER_ZERO_WRAP || (wr_core ? wd[BIT_TMR_FLAG] : tmr_flag); // R7 R13
      edge_flag <= edge_flag_set || (wr_core ? wd[BIT_EDGE_FLAG] : edge_flag); // R7 R10
      chg_flag <= port_change || (wr_core ? wd[BIT_CHG_FLAG] : chg_flag); // R7 R14
      pflag_a <= PERIPH_EVENT_A | (wr_pfa ? wd : pflag_a); // R7
      pflag_b <= (PERIPH_EVENT_B | (wr_pfb ? wd : pflag_b)) & PFLAG_B_MASK; // R7
      if (wr_pea)
        pen_a <= wd;
      if (wr_peb)
        pen_b <= wd & PFLAG_B_MASK;
      if (wr_opt)
        option_reg <= wd;
      if (wr_ans)
        analog_sel <= wd;
      if (wr_pce)
        pin_chg_en <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request combining
  logic core_any;
  logic periph_any;
  logic wake_cond;
  assign core_any = (tmr_flag && tmr_en) || (edge_flag && edge_en) || // R13
                    (chg_flag && chg_en); // R14
  assign periph_any = |(pflag_a & pen_a) || |(pflag_b & pen_b);
  assign wake_cond = core_any || (grp_en && periph_any); // R20 R21
  assign irq_line = wake_cond && glb_en; // R1

  ////////////////////////////////////////////////////////////////////////////
  // Vector sequencer, stepping once per instruction cycle
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (irq_line && !SLEEPING)
          next_state = ST_FINISH;
      ST_FINISH:
        next_state = glb_en ? ST_DUMMY1 : ST_RUN; // R8
      ST_DUMMY1:
        next_state = ST_DUMMY2;
      ST_DUMMY2:
        next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  logic enter_dummy;
  logic vector_fire;
  assign enter_dummy = q1 && (state == ST_FINISH) && glb_en;
  assign vector_fire = q1 && (state == ST_DUMMY2);

  always_ff @(posedge CLK)
  begin
    if (RESET)
      state <= ST_RUN;
    else if (q1)
      state <= next_state; // R5 R6
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
      glb_en <= CORE_CTRL_RST[BIT_GLB_EN]; // R2
    else if (INSTR_IRQ_RETURN)
      glb_en <= 1'b1; // R3
    else if (enter_dummy)
      glb_en <= 1'b0; // R4
    else if (wr_core)
      glb_en <= wd[BIT_GLB_EN];
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      VECTOR_REQ <= 1'b0;
      STACK_PUSH <= 1'b0;
      VECTOR_ADDR <= IRQ_VECTOR;
      WAKE <= 1'b0;
    end
    else
    begin
      VECTOR_REQ <= vector_fire; // R4
      STACK_PUSH <= vector_fire; // R4 R18
      VECTOR_ADDR <= IRQ_VECTOR; // R4
      WAKE <= wake_cond && SLEEPING; // R11 R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_enable_after_reset: assert property ( // R2
    @(posedge CLK) disable iff (1'b0) RESET |=> !glb_en)
    else $error("global enable not cleared by reset");
  a_enable_gates_entry: assert property ( // R1
    (state == ST_RUN) && q1 && !glb_en |=> state == ST_RUN)
    else $error("sequence started with global enable clear");
  a_clear_suppress: assert property ( // R8
    (state == ST_FINISH) && q1 && !glb_en |=> state == ST_RUN)
    else $error("request not dropped after global enable cleared");
  a_return_sets: assert property (INSTR_IRQ_RETURN |=> glb_en) // R3
    else $error("return from interrupt did not set global enable");
  a_vector_entry: assert property ( // R4
    VECTOR_REQ |-> STACK_PUSH && VECTOR_ADDR == IRQ_VECTOR && !glb_en)
    else $error("vector without push, with wrong address or with enable set");
  a_enable_cleared: assert property ($rose(state == ST_DUMMY1) |-> !glb_en) // R4
    else $error("global enable still set on service");
  a_fixed_latency: assert property ($rose(state == ST_DUMMY1) |-> ##8 VECTOR_REQ) // R5
    else $error("vector not eight clocks after first dummy cycle");
  a_single_pulse: assert property (VECTOR_REQ |=> !VECTOR_REQ [*3]) // R6
    else $error("vector request longer than one cycle");
  a_timer_flag: assert property (TIMER_ZERO_WRAP |=> tmr_flag) // R7
    else $error("timer wrap lost");
  a_edge_window: assert property ( // R12
    $rose(edge_flag) && !$past(wr_core) |-> $past(flag_window))
    else $error("edge flag set outside phase four to one");
  a_edge_flag: assert property (ext_edge && flag_window |=> edge_flag) // R10
    else $error("valid edge did not set flag");
  a_port_flag: assert property (port_change |=> chg_flag) // R14
    else $error("port change did not set flag");
  a_seg_blocks: assert property (SEG_ACTIVE && !edge_pend |=> !edge_pend) // R16
    else $error("edge detected while segment function active");
  a_group_gate: assert property (irq_line |-> core_any || grp_en) // R20
    else $error("peripheral request passed with group enable clear");
  a_wake_any: assert property (wake_cond && SLEEPING |=> WAKE) // R19
    else $error("enabled flagged interrupt did not wake");

  c_vector: cover property (VECTOR_REQ);
  c_abort: cover property ((state == ST_FINISH) && q1 && !glb_en);
  c_wake_no_enable: cover property (WAKE && !glb_en);
  c_return: cover property (INSTR_IRQ_RETURN && !glb_en);
endmodule : mic_irq_ctrl
`default_nettype wire

/* File: tb/mic_core_model.sv */
`default_nettype none
module mic_core_model
  import mic_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic vreq,
  input wire logic push,
  input wire logic [PC_W-1:0] vaddr,
  input wire logic ret_go,
  output var logic ret_instr,
  output var logic [PC_W-1:0] pc,
  output var int depth
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sequencer side: loads PC, keeps stack depth, returns on request
  always @(posedge clk)
  begin
    if (rst)
    begin
      depth <= 0;
      pc <= '0;
      ret_instr <= 1'b0;
    end
    else
    begin
      if (vreq)
        pc <= vaddr;
      if (push)
        depth <= depth + 1;
      else if (ret_go && depth > 0 && !ret_instr)
        depth <= depth - 1;
      ret_instr <= !push && ret_go && depth > 0 && !ret_instr;
    end
  end
endmodule : mic_core_model
`default_nettype wire

/* File: tb/tb_mcu_interrupt_controller.sv */
`default_nettype none
module tb_mcu_interrupt_controller
  import mic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic waitreq;
  logic [PORT_W-1:0] pins = '0;
  logic seg = 1'b0;
  logic t0w = 1'b0;
  logic [REG_W-1:0] ev = '0;
  logic prd = 1'b0;
  logic sleeping = 1'b0;
  logic vreq, push, wake, ret_instr;
  logic ret_go = 1'b0;
  logic [PC_W-1:0] vaddr, pc;
  int depth;
  int n_errors = 0;
  int cmp_count = 0;
  int n_vec = 0;
  int cyc = 0;
  int t_ev = 0;
  int k;
  integer seed = 32'h872b69f6;
  logic [31:0] r;
  logic [7:0] m [256];
  logic [7:0] regs [8] = '{IDX_CORE_CTRL, IDX_PFLAG_A, IDX_PFLAG_B, IDX_OPTION,
    IDX_PEN_A, IDX_PEN_B, IDX_ANALOG_SEL, IDX_PIN_CHG_EN};
  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  mic_irq_ctrl dut (.CLK(clk), .RESET(rst), .ADDRESS(addr), .READ(rd_en),
    .WRITE(wr_en), .WRITEDATA(wdata), .BYTEENABLE(4'hf), .READDATA(rdata),
    .WAITREQUEST(waitreq), .PORT_B_PINS(pins), .SEG_ACTIVE(seg),
    .TIMER_ZERO_WRAP(t0w), .PERIPH_EVENT_A(ev), .PERIPH_EVENT_B(ev),
    .PORT_READ(prd), .INSTR_IRQ_RETURN(ret_instr), .SLEEPING(sleeping),
    .VECTOR_REQ(vreq), .STACK_PUSH(push), .VECTOR_ADDR(vaddr), .WAKE(wake));
  mic_core_model core (.clk(clk), .rst(rst), .vreq(vreq), .push(push),
    .vaddr(vaddr), .ret_go(ret_go), .ret_instr(ret_instr), .pc(pc), .depth(depth));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
    output logic [7:0] q);
    int i;
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd_en <= !w;
    wr_en <= w;
    wdata <= {24'h0, d};
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (waitreq !== 1'b0 && i < 20);
    q = rdata[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    chk("waitrequest", 0, waitreq);
  endtask : bus
  function automatic logic [7:0] msk(input logic [7:0] idx);
    case (idx)
      IDX_PFLAG_B, IDX_PEN_B: return PFLAG_B_MASK;
      IDX_CORE_CTRL, IDX_PFLAG_A, IDX_OPTION, IDX_PEN_A: return 8'hff;
      IDX_ANALOG_SEL, IDX_PIN_CHG_EN: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction : msk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
    if (msk(idx) != 8'h00)
      m[idx] = d & msk(idx);
  endtask : wr
  task automatic rd(input logic [7:0] idx);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk($sformatf("reg %h", idx), {24'h0, m[idx]}, {24'h0, q});
  endtask : rd
  task automatic pin(input int b, input logic v);
    @(posedge clk);
    pins[b] <= v;
    repeat (12) @(posedge clk);
  endtask : pin
  task automatic pulse(input logic t, input logic [7:0] a);
    @(posedge clk);
    t0w <= t;
    ev <= a;
    t_ev = cyc;
    @(posedge clk);
    t0w <= 1'b0;
    ev <= 8'h00;
  endtask : pulse
  task automatic snap();
    @(posedge clk);
    prd <= 1'b1;
    repeat (4) @(posedge clk);
    prd <= 1'b0;
  endtask : snap
  task automatic vwait(input int n);
    repeat (40) @(posedge clk);
    chk("vectors", n, n_vec);
  endtask : vwait
  task automatic ret();
    int i;
    @(posedge clk);
    ret_go <= 1'b1;
    for (i = 0; i < 20 && depth != 0; i++)
      @(posedge clk);
    ret_go <= 1'b0;
    m[IDX_CORE_CTRL][BIT_GLB_EN] = 1'b1;
    rd(IDX_CORE_CTRL);
  endtask : ret
  task automatic conclude();
    if (n_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
    if (vreq === 1'b1)
    begin
      n_vec++;
      chk("latency", 1, (cyc - t_ev) >= LAT_MIN_TCY * PHASES_PER_TCY &&
        (cyc - t_ev) <= (LAT_MAX_TCY + 2) * PHASES_PER_TCY);
      chk("stack push", 1, push);
      chk("vector addr", IRQ_VECTOR, vaddr);
    end
  initial
  begin
    #200000;
    n_errors++;
    conclude();
  end
  initial
  begin
    foreach (m[i]) m[i] = 8'h00;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 8; k++)
      rd(regs[k]);
    rd(8'h20);
    for (k = 1; k < 8; k++)
    begin
      r = $random(seed);
      wr(regs[k], r[7:0]);
      rd(regs[k]);
      wr(regs[k], 8'h00);
    end
    pulse(1'b1, 8'h01);
    repeat (8) @(posedge clk);
    m[IDX_CORE_CTRL] = 8'h04;
    m[IDX_PFLAG_A] = 8'h01;
    m[IDX_PFLAG_B] = 8'h01;
    for (k = 0; k < 3; k++)
    begin
      rd(regs[k]);
      wr(regs[k], 8'h00);
    end
    vwait(0);
    for (k = 0; k < 2; k++)
    begin
      wr(IDX_OPTION, k ? 8'h40 : 8'h00);
      pin(EXT_PIN_BIT, !k);
      wr(IDX_CORE_CTRL, 8'h00);
      pin(EXT_PIN_BIT, k);
      m[IDX_CORE_CTRL] = 8'h02;
      rd(IDX_CORE_CTRL);
      wr(IDX_CORE_CTRL, 8'h00);
      pin(EXT_PIN_BIT, !k);
      rd(IDX_CORE_CTRL);
    end
    for (k = 0; k < 2; k++)
    begin
      if (k == 0)
        seg <= 1'b1;
      else
        wr(IDX_ANALOG_SEL, 8'h01);
      pin(EXT_PIN_BIT, 1'b1);
      rd(IDX_CORE_CTRL);
      seg <= 1'b0;
      wr(IDX_ANALOG_SEL, 8'h00);
      pin(EXT_PIN_BIT, 1'b0);
      wr(IDX_CORE_CTRL, 8'h00);
    end
    wr(IDX_PIN_CHG_EN, 8'h80);
    snap();
    wr(IDX_CORE_CTRL, 8'h00);
    pin(6, 1'b1);
    rd(IDX_CORE_CTRL);
    pin(7, 1'b1);
    m[IDX_CORE_CTRL] = 8'h01;
    rd(IDX_CORE_CTRL);
    snap();
    wr(IDX_CORE_CTRL, 8'h00);
    rd(IDX_CORE_CTRL);
    wr(IDX_PIN_CHG_EN, 8'h00);
    wr(IDX_CORE_CTRL, 8'ha0);
    pulse(1'b1, 8'h00);
    vwait(1);
    m[IDX_CORE_CTRL] = 8'h24;
    rd(IDX_CORE_CTRL);
    chk("pc", IRQ_VECTOR, pc);
    chk("depth", 1, depth);
    wr(IDX_CORE_CTRL, 8'h20);
    ret();
    vwait(1);
    wr(IDX_CORE_CTRL, 8'h20);
    pulse(1'b1, 8'h00);
    vwait(1);
    m[IDX_CORE_CTRL] = 8'h24;
    rd(IDX_CORE_CTRL);
    t_ev = cyc;
    wr(IDX_CORE_CTRL, 8'ha4);
    vwait(2);
    wr(IDX_CORE_CTRL, 8'h20);
    ret();
    wr(IDX_PEN_A, 8'h01);
    wr(IDX_CORE_CTRL, 8'h80);
    pulse(1'b0, 8'h01);
    vwait(2);
    t_ev = cyc;
    wr(IDX_CORE_CTRL, 8'hc0);
    vwait(3);
    wr(IDX_PFLAG_A, 8'h00);
    ret();
    wr(IDX_CORE_CTRL, 8'h10);
    sleeping <= 1'b1;
    wr(IDX_CORE_CTRL, 8'h12);
    repeat (4) @(posedge clk);
    chk("wake", 1, wake);
    wr(IDX_CORE_CTRL, 8'h02);
    repeat (4) @(posedge clk);
    chk("wake", 0, wake);
    vwait(3);
    conclude();
  end
endmodule : tb_mcu_interrupt_controller
`default_nettype wire
